// ===== shr4_pkg.sv
// shared constants for the four-bit bidirectional universal shift register
package shr4_pkg;
	// ============================================================
	// geometry
	localparam int STAGES = 4;
	// ============================================================
	// mode select codes, written as {modeSelectHi, modeSelectLo}
	localparam logic [1:0] MODE_HOLD = 2'h0;
	localparam logic [1:0] MODE_RIGHT = 2'h1;
	localparam logic [1:0] MODE_LEFT = 2'h2;
	localparam logic [1:0] MODE_LOAD = 2'h3;
	// ============================================================
	// clear synchroniser values, at clear and once released
	localparam logic [1:0] CLR_SYNC_RESET = 2'h0;
	localparam logic [1:0] CLR_SYNC_RELEASED = 2'h3;
	// ============================================================
	// cycles from clear release until clocked operation resumes
	localparam int CLR_RELEASE_CYCLES = 2;
endpackage

// ===== shr4_shift_reg.sv
// four-bit bidirectional universal shift register with direct clear
`timescale 1ns/1ns
module shr4_shift_reg #(
	parameter int WIDTH = shr4_pkg::STAGES
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic clearN, // direct clear, active low, asynchronous
	input wire logic modeSelectLo, // mode select, low bit
	input wire logic modeSelectHi, // mode select, high bit
	input wire logic serRight, // serial data entering the first stage on right shift
	input wire logic serLeft, // serial data entering the last stage on left shift
	input wire logic [WIDTH-1:0] parIn, // parallel data, bit 0 is the first stage
	output logic [WIDTH-1:0] parOut // stored state, bit 0 is the first stage
);

	// ============================================================
	// clear release synchroniser
	// assertion of clear is immediate; only its release is retimed, so the
	// register never leaves clear on a partial edge. costs two idle cycles.
	logic [1:0] clrSync_q;

	always_ff @(posedge clk or negedge clearN) begin
		if (!clearN) begin
			clrSync_q <= shr4_pkg::CLR_SYNC_RESET;
		end else begin
			clrSync_q <= {clrSync_q[0], 1'h1};
		end
	end

	wire logic runOk;
	assign runOk = clrSync_q[1];

	// ============================================================
	// mode decode
	wire logic [1:0] modeSel;
	wire logic isLoad;
	wire logic isRight;
	wire logic isLeft;
	wire logic isHold;
	assign modeSel = {modeSelectHi, modeSelectLo};
	assign isLoad = (modeSel == shr4_pkg::MODE_LOAD);
	assign isRight = (modeSel == shr4_pkg::MODE_RIGHT);
	assign isLeft = (modeSel == shr4_pkg::MODE_LEFT);
	assign isHold = (modeSel == shr4_pkg::MODE_HOLD);

	// ============================================================
	// per-stage next value
	logic [WIDTH-1:0] state_q;
	wire logic [WIDTH-1:0] state_d;
	wire logic [WIDTH-1:0] fromLow;
	wire logic [WIDTH-1:0] fromHigh;

	// neighbour feeding each stage on a right and on a left shift
	assign fromLow = {state_q[WIDTH-2:0], serRight};
	assign fromHigh = {serLeft, state_q[WIDTH-1:1]};

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_stage
			// serial inputs reach a stage only through the shift terms
			assign state_d[gi] = isLoad ? parIn[gi] :
				isRight ? fromLow[gi] :
				isLeft ? fromHigh[gi] :
				state_q[gi];
		end
	endgenerate

	// ============================================================
	// state register
	always_ff @(posedge clk or negedge clearN) begin
		if (!clearN) begin
			state_q <= '0;
		end else if (rst || !runOk) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign parOut = state_q;

	// ============================================================
	// assertions
	// helper: clear fell since the last edge, seen at the next edge
	logic clrSeen_q;
	always_ff @(posedge clk or negedge clearN) begin
		if (!clearN) begin
			clrSeen_q <= 1'h1;
		end else begin
			clrSeen_q <= 1'h0;
		end
	end

	// stepOk marks the edges at which a mode really applies; every other edge
	// forces zero, so the mode checks below stay quiet there
	wire logic stepOk;
	assign stepOk = runOk && !rst && !clrSeen_q;

	parallel_load_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad |=> parOut == $past(parIn))
		else $error("parallel load did not capture parallel inputs");

	load_ignores_serial_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad && serRight && serLeft |=> parOut == $past(parIn))
		else $error("serial data leaked into a parallel load");

	// each serial input set against its end stage, so any leak shows
	load_blocks_right_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad && (serRight != parIn[0]) |=> parOut[0] == $past(parIn[0]))
		else $error("right serial input reached the first stage during a load");

	load_blocks_left_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad && (serLeft != parIn[WIDTH-1])
			|=> parOut[WIDTH-1] == $past(parIn[WIDTH-1]))
		else $error("left serial input reached the last stage during a load");

	shift_right_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isRight |=> parOut[WIDTH-1:1] == $past(parOut[WIDTH-2:0]))
		else $error("right shift did not move bits toward the last stage");

	right_serial_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isRight |=> parOut[0] == $past(serRight))
		else $error("right serial input did not enter the first stage");

	shift_left_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLeft |=> parOut[WIDTH-2:0] == $past(parOut[WIDTH-1:1])
			&& parOut[WIDTH-1] == $past(serLeft))
		else $error("left shift wrong or left serial input not in last stage");

	left_serial_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isLeft |=> parOut[WIDTH-1] == $past(serLeft))
		else $error("left serial input did not enter the last stage");

	hold_mode_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isHold |=> $stable(parOut))
		else $error("hold mode changed the stored bits");

	// parallel data moving under hold must not reach the stages
	hold_ignores_data_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isHold && $changed(parIn) |=> $stable(parOut))
		else $error("parallel data changed the stored bits in hold mode");

	hold_run_a: assert property (@(posedge clk) disable iff (!clearN)
		stepOk && isHold ##1 stepOk && isHold |=> parOut == $past(parOut, 2))
		else $error("state drifted across two held edges");

	clear_forces_a: assert property (@(posedge clk)
		!clearN |-> parOut == '0)
		else $error("outputs not low while clear is asserted");

	// clear sampled low at an edge must win over whatever mode that edge carries
	clear_beats_clock_a: assert property (@(posedge clk)
		!clearN |=> parOut == '0)
		else $error("a clock edge overrode an asserted clear");

	clear_release_a: assert property (@(posedge clk) disable iff (!clearN)
		clrSeen_q |-> parOut == '0 ##1 parOut == '0 ##1 parOut == '0)
		else $error("state left zero before clear release settled");

	// release is retimed: two dead edges, then the third edge applies a mode
	release_delay_a: assert property (@(posedge clk) disable iff (!clearN)
		clrSeen_q |-> !runOk ##1 !runOk ##1 runOk)
		else $error("clear release did not take exactly two dead edges");

	settling_zero_a: assert property (@(posedge clk) disable iff (!clearN)
		!runOk |=> parOut == '0)
		else $error("state moved while clear release was still settling");

	resume_after_a: assert property (@(posedge clk) disable iff (!clearN)
		clrSeen_q ##2 (!rst && isLoad) |=> parOut == $past(parIn))
		else $error("clocked operation did not resume after clear release");

	sync_reset_a: assert property (@(posedge clk) disable iff (!clearN)
		rst |=> parOut == '0)
		else $error("synchronous reset did not zero the state");

	// ============================================================
	// per-stage checks, so a failure names the stage that went wrong
	// redundant with the whole-word checks above on purpose
	genvar gc;
	generate
		for (gc = 0; gc < WIDTH; gc++) begin : g_load_chk
			load_stage_a: assert property (@(posedge clk) disable iff (!clearN)
				stepOk && isLoad |=> parOut[gc] == $past(parIn[gc]))
				else $error("a stage did not take its own parallel input");
		end
		for (gc = 1; gc < WIDTH; gc++) begin : g_link_chk
			right_link_a: assert property (@(posedge clk) disable iff (!clearN)
				stepOk && isRight |=> parOut[gc] == $past(parOut[gc-1]))
				else $error("a stage missed its neighbour on a right shift");

			left_link_a: assert property (@(posedge clk) disable iff (!clearN)
				stepOk && isLeft |=> parOut[gc-1] == $past(parOut[gc]))
				else $error("a stage missed its neighbour on a left shift");
		end
	endgenerate

	// ============================================================
	// covers
	load_then_right_c: cover property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad ##1 stepOk && isRight);

	left_run_c: cover property (@(posedge clk) disable iff (!clearN)
		(stepOk && isLeft)[*4]);

	hold_after_load_c: cover property (@(posedge clk) disable iff (!clearN)
		stepOk && isLoad ##1 (stepOk && isHold)[*3]);

	clear_mid_run_c: cover property (@(posedge clk)
		stepOk && isRight ##1 !clearN);

	release_load_c: cover property (@(posedge clk) disable iff (!clearN)
		clrSeen_q ##2 (runOk && isLoad));
endmodule

// ===== shr4_src.sv
// far-side model: logic that drives modes and data, changing at the falling edge
`timescale 1ns/1ns
module shr4_src (
	input wire logic clk, // bench clock
	input wire logic [1:0] mode, // next {hi,lo}
	input wire logic sr, // next right serial bit
	input wire logic sl, // next left serial bit
	input wire logic [3:0] p, // next parallel word
	output logic modeSelectLo, // to device
	output logic modeSelectHi, // to device
	output logic serRight, // to device
	output logic serLeft, // to device
	output logic [3:0] parIn // to device
);
	// starts at zero so the device never sees an unknown input
	logic [7:0] drv_q = 8'h00;
	assign {modeSelectHi, modeSelectLo, serRight, serLeft, parIn} = drv_q;
	always_ff @(negedge clk) begin
		drv_q <= {mode, sr, sl, p};
	end
endmodule

// ===== bidir_universal_shift_reg4_tb.sv
// self-checking bench for the shift register
`timescale 1ns/1ns
module bidir_universal_shift_reg4_tb;
	logic clk, rst, clearN, sr, sl, srQ, slQ, lo, hi;
	logic [1:0] m;
	logic [3:0] p, pQ, q, exp;
	int errors = 0, check_count = 0, hold = 0;
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	shr4_src i_src (.clk(clk), .mode(m), .sr(sr), .sl(sl), .p(p), .modeSelectLo(lo),
		.modeSelectHi(hi), .serRight(srQ), .serLeft(slQ), .parIn(pQ));
	shr4_shift_reg i_dut (.clk(clk), .rst(rst), .clearN(clearN), .modeSelectLo(lo),
		.modeSelectHi(hi), .serRight(srQ), .serLeft(slQ), .parIn(pQ), .parOut(q));
	// ============================================================
	// expectation and checking
	function automatic logic [3:0] nxt(logic [1:0] md, logic [3:0] s, logic r, logic l,
		logic [3:0] d);
		case (md)
			shr4_pkg::MODE_LOAD: return d;
			shr4_pkg::MODE_RIGHT: return {s[2:0], r};
			shr4_pkg::MODE_LEFT: return {l, s[3:1]};
			default: return s;
		endcase
	endfunction
	task automatic chk(string what, logic [3:0] e, logic [3:0] s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", what, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// clear level is applied at the same falling edge as the mode
	task automatic step(logic c, logic [1:0] md, logic r, logic l, logic [3:0] d);
		m = md;
		sr = r;
		sl = l;
		p = d;
		@(negedge clk) clearN = c;
		@(posedge clk);
		#1;
		if (!clearN) begin
			hold = 2;
			exp = 4'h0;
		end else if (hold > 0) hold--;
		else exp = nxt(md, exp, r, l, d);
		chk("parOut", exp, q);
	endtask
	// ============================================================
	// main sequence
	initial begin
		// clear stays off during reset: a low level set at time zero could slip
		// past the asynchronous clear before it is watched
		{rst, clearN, m, sr, sl, p, exp} = {2'h3, 12'h000};
		void'($urandom(32'h8c1fc1ac));
		repeat (4) @(posedge clk);
		@(negedge clk) rst = 1'h0;
		repeat (3) step(1'h1, shr4_pkg::MODE_HOLD, 1'h0, 1'h0, 4'h0);
		step(1'h1, shr4_pkg::MODE_LOAD, 1'h1, 1'h1, 4'ha);
		step(1'h1, shr4_pkg::MODE_RIGHT, 1'h1, 1'h0, 4'h0);
		step(1'h1, shr4_pkg::MODE_LEFT, 1'h0, 1'h1, 4'hf);
		step(1'h1, shr4_pkg::MODE_HOLD, 1'h1, 1'h1, 4'h3);
		// clear between edges must act at once, without a clock edge
		@(negedge clk) clearN = 1'h0;
		#2 chk("async clear", 4'h0, q);
		step(1'h0, shr4_pkg::MODE_LOAD, 1'h1, 1'h1, 4'hf);
		repeat (3) step(1'h1, shr4_pkg::MODE_LOAD, 1'h0, 1'h0, 4'h9);
		repeat (300) step($urandom % 25 != 0, 2'($urandom), 1'($urandom), 1'($urandom),
			4'($urandom));
		give_verdict();
	end
	// about 311 steps of 10 ns; generous margin before calling it a hang
	initial begin
		#50000;
		errors++;
		give_verdict();
	end
endmodule
